// [src/eepfe_dev.sv]
// Memory-side front end: conditions, word shifting, address check, write timing
// Overview of operation
// - Data changes only while clock low
// - Data fall under clock high: start
// - Data rise under clock high: stop, standby
// - Eight-bit words, receiver acks ninth clock
// - Standby at power-up and after stop
// - Controller recovers: start, nine clocks, start, stop
// - Recovery leaves device released and ready
// - Address word follows start, type checked
// - Address bits 3..1 match select inputs
// - Unconnected select inputs compare as zero
// - Six-ball and four-ball compare fixed zeros; six-ball here compares the high select input in bit 3
// - Five-ball compares zero, zero, one
// - Address bit 0: one reads, zero writes
// - Match acks; mismatch nacks, back to standby
// - Write-protect high blocks array writes
// - Internal write finishes within five milliseconds
// - No address ack during internal write
//
// The address map and the strobed register port were decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "eepfe_map.svh"
module eepfe_dev
  import eepfe_pkg::*;
#(
  parameter eepfe_pkgopt_e PKG_OPT    = PKG_PINS,
  // Device type code; value is arbitrary
  parameter logic [3:0]    TYPE_ID    = `EEPFE_DEV_TYPE,
  parameter int            WR_CYCLES  = `EEPFE_INTERNAL_WRITE_CYCLE_TIME_NS / `EEPFE_CLK_NS
)(
  input  wire logic       ref_clk_in,
  input  wire logic       rstn_in,
  eepfe_bus_if.dev        bus,
  input  wire logic       chip_select_bit_high_in,
  input  wire logic       chip_select_bit_mid_in,
  input  wire logic       chip_select_bit_low_in,
  input  wire logic       wp_in,
  input  wire logic [7:0] rd_data_in,
  output logic            cmd_valid_out,
  output logic            cmd_read_out,
  output logic            byte_valid_out,
  output logic [7:0]      byte_data_out,
  output logic            rd_next_out,
  output logic            wr_commit_out,
  output logic            busy_out,
  output logic            standby_out
);
  localparam logic [17:0] WR_LOAD = 18'(WR_CYCLES);

  eepfe_dev_s q;
  eepfe_dev_s d;
  logic       scl_rise;
  logic       scl_fall;
  logic       start_c;
  logic       stop_c;
  logic       wp_eff;
  logic       match;
  logic       load_tx;
  logic [2:0] cs_exp;

  //////////////////////////////////////////////////////////////////////////////
  // Bus condition decode from the synchronised copies (stages 1 and 2 only)
  always_comb begin
    scl_rise = q.scl_sy[1] & ~q.scl_sy[2];
    scl_fall = ~q.scl_sy[1] & q.scl_sy[2];
    // Any data edge while clock stays high is a condition, never a bit
    start_c  = q.scl_sy[1] & q.scl_sy[2] & ~q.sda_sy[1] & q.sda_sy[2];
    stop_c   = q.scl_sy[1] & q.scl_sy[2] & q.sda_sy[1] & ~q.sda_sy[2];
    // Package without the protect input never blocks writes
    wp_eff   = q.wp_sy[1] & (PKG_OPT != PKG_BALL4);
  end

  //////////////////////////////////////////////////////////////////////////////
  // Expected select bits per package option; absent balls compare as fixed values
  always_comb begin
    unique case (PKG_OPT)
      PKG_PINS:  cs_exp = q.cs_sy[1];
      PKG_BALL6: cs_exp = {q.cs_sy[1][2], 2'h0};
      PKG_BALL5: cs_exp = `EEPFE_CS_BALL5;
      PKG_BALL4: cs_exp = `EEPFE_CS_ZERO;
    endcase
    match = (q.sh[`EEPFE_TYPE_MSB:`EEPFE_TYPE_LSB] == TYPE_ID)
          & (q.sh[`EEPFE_CS_MSB:`EEPFE_CS_LSB] == cs_exp);
  end

  //////////////////////////////////////////////////////////////////////////////
  // Next-state logic; every strobe output is a single-cycle flag
  always_comb begin
    d = q;
    load_tx = 1'b0;
    d.cmd_valid = 1'b0;
    d.byte_valid = 1'b0;
    d.rd_next = 1'b0;
    d.wr_commit = 1'b0;
    d.scl_sy = {q.scl_sy[1:0], bus.scl};
    d.sda_sy = {q.sda_sy[1:0], bus.sda};
    d.cs_sy = {q.cs_sy[0], {chip_select_bit_high_in, chip_select_bit_mid_in,
                            chip_select_bit_low_in}};
    d.wp_sy = {q.wp_sy[0], wp_in};

    // Self-timed write; the count is the longest allowed, rounded down
    if (q.busy) begin
      d.timer = q.timer - 18'h1;
      if (q.timer == 18'h1) d.busy = 1'b0;
    end

    if (start_c) begin
      // A start aborts any bus transfer in flight, from any state; an internal write runs on
      d.st = D_ADDR;
      d.bitcnt = 4'h0;
      d.sda_oe = 1'b0;
      d.wr_seen = 1'b0;
    end else if (stop_c) begin
      // Stop ends the frame; a write with data launches the array cycle
      d.st = D_IDLE;
      d.sda_oe = 1'b0;
      if (q.st != D_IGN && q.wr_seen && !q.rw && !q.busy && !wp_eff) begin
        d.wr_commit = 1'b1;
        d.busy = 1'b1;
        d.timer = WR_LOAD;
      end
      d.wr_seen = 1'b0;
    end else begin
      unique case (q.st)
        D_IDLE, D_IGN: begin
          // Released and deaf until the next start
          d.sda_oe = 1'b0;
        end
        D_ADDR, D_WRX: begin
          // Sample data on rising clock, decide the ack on the eighth fall
          if (scl_rise && q.bitcnt != `EEPFE_WORD_BITS) begin
            d.sh = {q.sh[6:0], q.sda_sy[1]};
            d.bitcnt = q.bitcnt + 4'h1;
          end
          if (scl_fall && q.bitcnt == `EEPFE_WORD_BITS) begin
            if (q.st == D_WRX) begin
              d.sda_oe = 1'b1;
              d.st = D_ACK;
              d.byte_valid = 1'b1;
              d.byte_data = q.sh;
              d.wr_seen = 1'b1;
            end else if (match && !q.busy) begin
              d.sda_oe = 1'b1;
              d.st = D_ACK;
              d.rw = q.sh[`EEPFE_RW_BIT];
              d.cmd_valid = 1'b1;
              d.cmd_read = q.sh[`EEPFE_RW_BIT];
            end else begin
              d.st = D_IGN;
            end
          end
        end
        D_ACK: begin
          // Ack held through the ninth clock, released at its fall
          if (scl_fall) begin
            d.sda_oe = 1'b0;
            d.bitcnt = 4'h0;
            if (q.rw) begin
              load_tx = 1'b1;
            end else begin
              d.st = D_WRX;
            end
          end
        end
        D_TXB: begin
          // Read bits move out on falling clock, open-drain low only
          if (scl_rise) d.bitcnt = q.bitcnt + 4'h1;
          if (scl_fall) begin
            if (q.bitcnt == `EEPFE_WORD_BITS) begin
              d.sda_oe = 1'b0;
              d.st = D_RACK;
            end else begin
              d.sh = {q.sh[6:0], 1'b0};
              d.sda_oe = ~q.sh[6];
            end
          end
        end
        D_RACK: begin
          // Controller acks to ask for more; a nack waits for the stop
          if (scl_rise) d.rx_ack = ~q.sda_sy[1];
          if (scl_fall) begin
            if (q.rx_ack) begin
              load_tx = 1'b1;
            end else begin
              d.st = D_IGN;
            end
          end
        end
        default: d.st = D_IDLE;
      endcase
    end

    // Fetch a read byte and put its first bit out
    if (load_tx) begin
      d.st = D_TXB;
      d.bitcnt = 4'h0;
      d.sh = rd_data_in;
      d.sda_oe = ~rd_data_in[7];
      d.rd_next = 1'b1;
    end

    // Standby in idle or while ignoring a frame, once no internal operation remains
    d.standby = (d.st == D_IDLE || d.st == D_IGN) && !d.busy;
  end

  //////////////////////////////////////////////////////////////////////////////
  // State register; power-up lands in standby with the bus seen as idle
  always_ff @(posedge ref_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      q <= '{st: D_IDLE, scl_sy: 3'h7, sda_sy: 3'h7, standby: 1'b1, default: '0};
    end else begin
      q <= d;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Outputs straight from the state register; data output tied low
  assign bus.dev_sda_oe  = q.sda_oe;
  assign bus.dev_sda_out = 1'b0;
  assign cmd_valid_out   = q.cmd_valid;
  assign cmd_read_out    = q.cmd_read;
  assign byte_valid_out  = q.byte_valid;
  assign byte_data_out   = q.byte_data;
  assign rd_next_out     = q.rd_next;
  assign wr_commit_out   = q.wr_commit;
  assign busy_out        = q.busy;
  assign standby_out     = q.standby;
endmodule
`default_nettype wire

// [pkg/eepfe_map.svh]
// Named constants for the serial memory front end and its bus controller
`ifndef EEPFE_MAP_SVH
`define EEPFE_MAP_SVH
`define EEPFE_CLK_NS                      20
`define EEPFE_INTERNAL_WRITE_CYCLE_TIME_NS 5000000
`define EEPFE_QTR_NS                      800
`define EEPFE_WORD_BITS                   4'h8
`define EEPFE_TYPE_MSB                    7
`define EEPFE_TYPE_LSB                    4
`define EEPFE_CS_MSB                      3
`define EEPFE_CS_LSB                      1
`define EEPFE_RW_BIT                      0
`define EEPFE_DEV_TYPE                    4'h6
`define EEPFE_CS_BALL5                    3'h1
`define EEPFE_CS_ZERO                     3'h0
`define EEPFE_REG_CMD                     4'h0
`define EEPFE_REG_TXD                     4'h4
`define EEPFE_REG_STAT                    4'h8
`define EEPFE_CMD_START                   0
`define EEPFE_CMD_STOP                    1
`define EEPFE_CMD_WRB                     2
`define EEPFE_CMD_RDB                     3
`define EEPFE_CMD_ACKV                    4
`define EEPFE_CMD_RECOV                   5
`define EEPFE_BIT_COUNT                   4'h9
`define EEPFE_REC_OPS                     2'h3
`endif

// [pkg/eepfe_pkg.sv]
// Types shared by the memory front end and the bus controller
package eepfe_pkg;
  typedef enum logic [6:0] {
    D_IDLE = 7'h01, D_ADDR = 7'h02, D_ACK = 7'h04, D_WRX = 7'h08,
    D_TXB = 7'h10, D_RACK = 7'h20, D_IGN = 7'h40
  } eepfe_dst_e;
  typedef enum logic [3:0] {
    C_IDLE = 4'h1, C_START = 4'h2, C_STOP = 4'h4, C_BITS = 4'h8
  } eepfe_cst_e;
  typedef enum logic [1:0] {
    PKG_PINS = 2'h0, PKG_BALL6 = 2'h1, PKG_BALL5 = 2'h2, PKG_BALL4 = 2'h3
  } eepfe_pkgopt_e;
  typedef struct packed {
    logic [2:0]       scl_sy;
    logic [2:0]       sda_sy;
    logic [1:0][2:0]  cs_sy;
    logic [1:0]       wp_sy;
    eepfe_dst_e       st;
    logic [3:0]       bitcnt;
    logic [7:0]       sh;
    logic             rw;
    logic             rx_ack;
    logic             wr_seen;
    logic             sda_oe;
    logic             busy;
    logic [17:0]      timer;
    logic             cmd_valid;
    logic             cmd_read;
    logic             byte_valid;
    logic [7:0]       byte_data;
    logic             rd_next;
    logic             wr_commit;
    logic             standby;
  } eepfe_dev_s;
  typedef struct packed {
    logic             scl_oe;
    logic             sda_oe;
    logic [1:0]       sda_sy;
    eepfe_cst_e       st;
    logic [1:0]       qtr;
    logic [5:0]       cnt;
    logic [3:0]       nbits;
    logic [8:0]       tx;
    logic [8:0]       rx;
    logic [1:0]       rec;
    logic             busy;
    logic             ackrx;
    logic [7:0]       txd;
    logic [15:0]      rdata;
  } eepfe_ctl_s;
endpackage

// [pkg/eepfe_bus_if.sv]
// Two-wire bus between controller and memory front end, pulled high when released
`timescale 1ns/1ps
`default_nettype none
interface eepfe_bus_if;
  logic scl;
  logic sda;
  logic ctl_scl_oe;
  logic ctl_scl_out;
  logic ctl_sda_oe;
  logic ctl_sda_out;
  logic dev_sda_oe;
  logic dev_sda_out;
  // Wired-AND with pull-up: any enabled driver decides the level
  assign scl = ctl_scl_oe ? ctl_scl_out : 1'b1;
  assign sda = (ctl_sda_oe ? ctl_sda_out : 1'b1) & (dev_sda_oe ? dev_sda_out : 1'b1);
  modport dev (input scl, input sda, output dev_sda_oe, output dev_sda_out);
  modport ctl (input scl, input sda, output ctl_scl_oe, output ctl_scl_out,
               output ctl_sda_oe, output ctl_sda_out);
endinterface
`default_nettype wire

// [src/eepfe_ctl.sv]
// Bus controller end: register port in, bit-level two-wire sequences out
`timescale 1ns/1ps
`default_nettype none
`include "eepfe_map.svh"
module eepfe_ctl
  import eepfe_pkg::*;
(
  input  wire logic        ref_clk_in,
  input  wire logic        rstn_in,
  eepfe_bus_if.ctl         bus,
  input  wire logic [3:0]  reg_addr_in,
  input  wire logic [15:0] reg_wdata_in,
  input  wire logic        reg_wr_in,
  input  wire logic        reg_rd_in,
  output logic      [15:0] reg_rdata_out
);
  localparam int QTR_CYC = `EEPFE_QTR_NS / `EEPFE_CLK_NS;
  localparam logic [5:0] QTR_LAST = 6'(QTR_CYC - 1);

  eepfe_ctl_s q;
  eepfe_ctl_s d;
  logic       tick;

  //////////////////////////////////////////////////////////////////////////////
  // Quarter-period sequencer; scl is derived here, so no edge hunting needed
  always_comb begin
    d = q;
    d.sda_sy = {q.sda_sy[0], bus.sda};
    tick = (q.cnt == QTR_LAST);
    d.cnt = (q.st == C_IDLE || tick) ? 6'h0 : q.cnt + 6'h1;
    if (q.st != C_IDLE && tick) begin
      d.qtr = q.qtr + 2'h1;
      unique case (q.st)
        C_START: begin
          // Release data while clock low, raise clock, then drop data
          if (q.qtr == 2'h0) d.sda_oe = 1'b0;
          if (q.qtr == 2'h1) d.scl_oe = 1'b0;
          if (q.qtr == 2'h2) d.sda_oe = 1'b1;
          if (q.qtr == 2'h3) d.scl_oe = 1'b1;
        end
        C_STOP: begin
          // Data low under clock low, raise clock, then release data
          if (q.qtr == 2'h0) d.sda_oe = 1'b1;
          if (q.qtr == 2'h1) d.scl_oe = 1'b0;
          if (q.qtr == 2'h2) d.sda_oe = 1'b0;
        end
        C_BITS: begin
          // Data only changes in the clock-low quarter
          if (q.qtr == 2'h0) d.sda_oe = ~q.tx[8];
          if (q.qtr == 2'h1) d.scl_oe = 1'b0;
          if (q.qtr == 2'h2) d.rx = {q.rx[7:0], q.sda_sy[1]};
          if (q.qtr == 2'h3) begin
            d.scl_oe = 1'b1;
            d.tx = {q.tx[7:0], 1'b1};
            d.nbits = q.nbits - 4'h1;
          end
        end
        default: ;
      endcase
      // End of an operation: next recovery step or idle
      if (q.qtr == 2'h3 && (q.st != C_BITS || q.nbits == 4'h1)) begin
        d.ackrx = (q.st == C_BITS) ? q.sda_sy[1] : q.ackrx;
        unique case (q.rec)
          2'h3: begin
            d.st = C_BITS;
            d.tx = 9'h1ff;
            d.nbits = `EEPFE_BIT_COUNT;
          end
          2'h2: d.st = C_START;
          2'h1: d.st = C_STOP;
          2'h0: begin
            d.st = C_IDLE;
            d.busy = 1'b0;
          end
        endcase
        d.rec = (q.rec == 2'h0) ? 2'h0 : q.rec - 2'h1;
      end
    end
    // Register writes; commands are dropped while a sequence runs
    if (reg_wr_in && reg_addr_in == `EEPFE_REG_TXD) d.txd = reg_wdata_in[7:0];
    if (reg_wr_in && reg_addr_in == `EEPFE_REG_CMD && !q.busy) begin
      d.qtr = 2'h0;
      d.busy = 1'b1;
      d.busy = |reg_wdata_in[`EEPFE_CMD_RECOV:`EEPFE_CMD_START] & ~reg_wdata_in[`EEPFE_CMD_ACKV];
      if (reg_wdata_in[`EEPFE_CMD_ACKV]) d.busy = |reg_wdata_in[`EEPFE_CMD_RDB:`EEPFE_CMD_START]
                                                   | reg_wdata_in[`EEPFE_CMD_RECOV];
      if (reg_wdata_in[`EEPFE_CMD_RECOV]) begin
        d.st = C_START;
        d.rec = `EEPFE_REC_OPS;
      end else if (reg_wdata_in[`EEPFE_CMD_START]) d.st = C_START;
      else if (reg_wdata_in[`EEPFE_CMD_STOP]) d.st = C_STOP;
      else if (reg_wdata_in[`EEPFE_CMD_WRB] || reg_wdata_in[`EEPFE_CMD_RDB]) begin
        d.st = C_BITS;
        d.nbits = `EEPFE_BIT_COUNT;
        // Write: 8 data bits then release for the ack; read: release 8, then ack if ACKV set, else nack
        d.tx = reg_wdata_in[`EEPFE_CMD_WRB] ? {q.txd, 1'b1}
                                            : {8'hff, ~reg_wdata_in[`EEPFE_CMD_ACKV]};
      end
    end
    // Read data stand the cycle after the strobe only
    d.rdata = 16'h0;
    if (reg_rd_in) begin
      unique case (reg_addr_in)
        `EEPFE_REG_TXD:  d.rdata = {8'h0, q.txd};
        `EEPFE_REG_STAT: d.rdata = {q.rx[8:1], 6'h0, q.ackrx, q.busy};
        default:         d.rdata = 16'h0;
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // State register
  always_ff @(posedge ref_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      q <= '{st: C_IDLE, sda_sy: 2'h3, default: '0};
    end else begin
      q <= d;
    end
  end

  assign bus.ctl_scl_oe  = q.scl_oe;
  assign bus.ctl_scl_out = 1'b0;
  assign bus.ctl_sda_oe  = q.sda_oe;
  assign bus.ctl_sda_out = 1'b0;
  assign reg_rdata_out   = q.rdata;
endmodule
`default_nettype wire

// [bench/eepfe_properties.sv]
// Wire-level checks of the memory front end on the shared two-wire bus
`timescale 1ns/1ps
`default_nettype none
module eepfe_properties (
  input wire logic ref_clk_in,
  input wire logic rstn_in,
  input wire logic scl,
  input wire logic sda,
  input wire logic dev_sda_oe,
  input wire logic dev_sda_out
);
  logic [3:0] cnt_q;
  logic       scl_q;
  logic       sda_q;
  logic       rw_q;
  logic       nack_q;
  logic       idle_q;
  wire        start = scl & scl_q & sda_q & !sda;
  wire        stop  = scl & scl_q & !sda_q & sda;

  ////////////////////////////////////////////////////////////////////////////////
  // Clock rises since start, direction bit and address outcome
  always_ff @(posedge ref_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      cnt_q  <= 4'hf;
      scl_q  <= 1'b1;
      sda_q  <= 1'b1;
      rw_q   <= 1'b0;
      nack_q <= 1'b0;
      idle_q <= 1'b1;
    end else begin
      scl_q <= scl;
      sda_q <= sda;
      if (start) begin
        cnt_q <= 4'h0;
      end else if (scl && !scl_q && cnt_q != 4'hf) begin
        cnt_q <= cnt_q + 4'h1; // Saturates so only the address ack is bit nine
      end
      if (scl && !scl_q && cnt_q == 4'h7) begin
        rw_q <= sda;
      end
      nack_q <= start ? 1'b0 : (nack_q | (cnt_q == 4'h9 && scl && scl_q && sda));
      idle_q <= start ? 1'b0 : (idle_q | stop);
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Every check on the one clock; reset clears them all
  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (!rstn_in);

  a_only_low: assert property (dev_sda_oe |-> !sda && !dev_sda_out)
    else $error("front end drove data high");
  a_rise_clk_low: assert property ($rose(dev_sda_oe) |-> !scl && !$past(scl))
    else $error("data pulled low while clock high");
  a_fall_clk_low: assert property ($fell(dev_sda_oe) |-> !scl)
    else $error("data released while clock high");
  a_addr_released: assert property ((cnt_q inside {[4'h1:4'h8]}) && scl && scl_q |-> !dev_sda_oe)
    else $error("front end drove during address bits");
  a_ack_held: assert property (cnt_q == 4'h8 && $rose(dev_sda_oe) |-> dev_sda_oe [*8])
    else $error("acknowledge dropped early");
  a_nack_silent: assert property (nack_q |-> !dev_sda_oe)
    else $error("front end active after mismatch");
  a_idle_released: assert property (idle_q |-> !dev_sda_oe)
    else $error("front end active after stop");
  a_write_release: assert property (cnt_q == 4'h9 && !rw_q && scl_q && !scl |-> ##[1:6] !dev_sda_oe)
    else $error("ack not released after ninth clock");

  c_start: cover property (start);
  c_stop: cover property (stop);
  c_ack: cover property (cnt_q == 4'h9 && scl && !sda);
  c_nack: cover property ($rose(nack_q));
endmodule
`default_nettype wire

// [bench/testbench.sv]
// Self-checking bench: bus controller drives the memory front end over one bus
`timescale 1ns/1ps
`default_nettype none
`include "eepfe_map.svh"
module testbench;
  import eepfe_pkg::*;
  localparam int         WRC  = 4000;
  localparam logic [5:0] K_ST = 6'h01;
  localparam logic [5:0] K_SP = 6'h02;
  localparam logic [5:0] K_WB = 6'h04;
  localparam logic [5:0] K_RB = 6'h08;
  localparam logic [5:0] K_RC = 6'h20;
  logic        ref_clk_in;
  logic        rstn_in;
  logic [3:0]  ra;
  logic [15:0] wd;
  logic        we;
  logic        re;
  logic [15:0] rd;
  logic [2:0]  cs;
  logic        wp;
  logic [7:0]  rdat;
  logic        cv;
  logic        cr;
  logic [7:0]  bd;
  logic        wc;
  logic        busy;
  logic        sb;
  logic [15:0] rv;
  int          miscompares = 0;
  int          checks = 0;
  int          n_cmd = 0;
  int          n_wc = 0;
  int          n_busy = 0;
  int          n_bv = 0;
  int          n_rn = 0;
  logic        bv;
  logic        rn;

  eepfe_bus_if bus_if ();
  eepfe_ctl eepfe_ctl_inst (.ref_clk_in(ref_clk_in), .rstn_in(rstn_in), .bus(bus_if.ctl),
    .reg_addr_in(ra), .reg_wdata_in(wd), .reg_wr_in(we), .reg_rd_in(re), .reg_rdata_out(rd));
  eepfe_dev #(.WR_CYCLES(WRC)) eepfe_dev_inst (.ref_clk_in(ref_clk_in), .rstn_in(rstn_in),
    .bus(bus_if.dev), .chip_select_bit_high_in(cs[2]), .chip_select_bit_mid_in(cs[1]),
    .chip_select_bit_low_in(cs[0]), .wp_in(wp), .rd_data_in(rdat), .cmd_valid_out(cv),
    .cmd_read_out(cr), .byte_valid_out(bv), .byte_data_out(bd), .rd_next_out(rn),
    .wr_commit_out(wc), .busy_out(busy), .standby_out(sb));
  eepfe_properties eepfe_properties_inst (.ref_clk_in(ref_clk_in), .rstn_in(rstn_in),
    .scl(bus_if.scl), .sda(bus_if.sda), .dev_sda_oe(bus_if.dev_sda_oe),
    .dev_sda_out(bus_if.dev_sda_out));

  ////////////////////////////////////////////////////////////////////////////////
  // Clock and a watchdog sized well above the expected run
  initial begin
    ref_clk_in = 1'b0;
    forever #10 ref_clk_in = ~ref_clk_in;
  end
  initial begin
    repeat (98000) @(posedge ref_clk_in);
    miscompares++;
    test_done();
  end
  // Count one-cycle pulses and busy cycles
  always @(posedge ref_clk_in) begin
    n_cmd += int'(cv === 1'b1);
    n_wc += int'(wc === 1'b1);
    n_busy += int'(busy === 1'b1);
    n_bv += int'(bv === 1'b1);
    n_rn += int'(rn === 1'b1);
  end

  ////////////////////////////////////////////////////////////////////////////////
  task automatic test_done();
    if (miscompares == 0 && checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic reg_wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge ref_clk_in);
    ra <= a;
    wd <= d;
    we <= 1'b1;
    @(posedge ref_clk_in);
    we <= 1'b0;
  endtask
  // Read data stand only in the cycle after the strobe
  task automatic reg_rd(input logic [3:0] a, output logic [15:0] d);
    @(posedge ref_clk_in);
    ra <= a;
    re <= 1'b1;
    @(posedge ref_clk_in);
    re <= 1'b0;
    #1 d = rd;
  endtask
  // Issue a command and poll status until idle; a stuck controller ends the run
  task automatic op(input logic [5:0] c);
    reg_wr(`EEPFE_REG_CMD, {10'h000, c});
    rv = 16'h0001;
    for (int i = 0; i < 3000 && rv[0] !== 1'b0; i++) reg_rd(`EEPFE_REG_STAT, rv);
    if (rv[0] !== 1'b0) begin
      miscompares++;
      test_done();
    end
  endtask
  task automatic send(input logic [7:0] b);
    reg_wr(`EEPFE_REG_TXD, {8'h00, b});
    op(K_WB);
  endtask
  // Address is taken only with right type, matching selects and no write pending
  function automatic logic exp_nack(input logic [7:0] w, input logic [2:0] c, input logic bz);
    return !(w[7:4] == `EEPFE_DEV_TYPE && w[3:1] == c && !bz);
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    logic [7:0] w;
    logic [2:0] cn;
    logic       e;
    int         k;
    int         kb;
    ra = 4'h0;
    wd = 16'h0000;
    we = 1'b0;
    re = 1'b0;
    cs = 3'h0;
    wp = 1'b0;
    rdat = 8'h00;
    rstn_in = 1'b0;
    repeat (12) @(posedge ref_clk_in);
    rstn_in <= 1'b1;
    void'($urandom(69671));
    @(posedge ref_clk_in);
    chk(sb, 1'b1);
    chk(busy, 1'b0);
    // Random address words; the first two keep the selects at zero as if unconnected
    for (int i = 0; i < 12; i++) begin
      w = 8'($urandom);
      cn = (i < 2) ? 3'h0 : 3'($urandom);
      if (i[0]) w[7:4] = `EEPFE_DEV_TYPE;
      if (i[1] || i < 2) w[3:1] = cn;
      cs <= cn;
      rdat <= 8'($urandom);
      k = n_cmd;
      kb = n_rn;
      op(K_ST);
      send(w);
      e = exp_nack(w, cn, 1'b0);
      chk(rv[1], e);
      chk(16'(n_cmd - k), !e);
      if (e) begin
        send(8'h00);
        chk(rv[1], 1'b1);
      end else if (w[0]) begin
        chk(cr, 1'b1);
        op(K_RB);
        chk(rv[15:8], rdat);
        chk(16'(n_rn - kb), 16'h0001);
      end else begin
        chk(cr, 1'b0);
      end
      op(K_SP);
      chk(sb, 1'b1);
    end
    // Timed write, with an address attempt while it runs
    cs <= 3'h5;
    w = 8'($urandom);
    k = n_wc;
    op(K_ST);
    send({`EEPFE_DEV_TYPE, 3'h5, 1'b0});
    kb = n_bv;
    send(8'h1f);
    send(w);
    chk(16'(n_bv - kb), 16'h0002);
    chk(rv[1], 1'b0);
    chk(bd, w);
    e = 1'b0;
    op(K_SP);
    k = n_wc - k;
    chk(16'(k), 16'h0001);
    k = n_busy;
    op(K_ST);
    send({`EEPFE_DEV_TYPE, 3'h5, 1'b1});
    chk(rv[1], 1'b1);
    op(K_SP);
    for (int j = 0; j < WRC && busy !== 1'b0; j++) @(posedge ref_clk_in);
    chk(16'((n_busy - k) <= WRC && busy === 1'b0), 16'h0001);
    // Write protect: data acked, nothing committed
    wp <= 1'b1;
    k = n_wc;
    op(K_ST);
    send({`EEPFE_DEV_TYPE, 3'h5, 1'b0});
    send(8'h20);
    chk(rv[1], 1'b0);
    op(K_SP);
    chk(16'(n_wc - k), 16'h0000);
    chk(busy, 1'b0);
    wp <= 1'b0;
    // Recovery in mid-write leaves the bus free and ready
    op(K_ST);
    send({`EEPFE_DEV_TYPE, 3'h5, 1'b0});
    op(K_RC);
    chk(bus_if.dev_sda_oe, 1'b0);
    op(K_ST);
    send({`EEPFE_DEV_TYPE, 3'h5, 1'b0});
    chk(rv[1], 1'b0);
    op(K_SP);
    test_done();
  end
endmodule
`default_nettype wire
